// file: rtl/reactive_apparent_energy_accumulator.sv
// Notes on behaviour
// - After reset reactive energy sums signed reactive samples, ignoring active sign.
// - Active-sign mode adds reactive when active positive, subtracts when negative.
// - Mode field per channel: 01 active-sign, 10 absolute, else signed.
// - Active-sign mode drives both reactive registers and the pulse outputs.
// - Absolute mode sums magnitude, drops no-load samples, feeds registers and pulses.
// - Both apparent power results refresh together at the 6.99 kHz sample rate.
// - Samples go into a 48-bit accumulator; each threshold crossing steps 24-bit energy.
// - Threshold gives at most one step per 4.83 us at full scale.
// - Energy registers wrap two's complement in both directions.
// - Energy registers clear on read unless clear-on-read bit 6 is low.
// - Half-full and overflow events per channel, gated by that channel's enables.
// - Apparent line-cycle enable accumulates over half line cycles; off at reset.
// - One shared half-cycle count serves both channels, up to 65535.
// - Period end loads registers, sets cycle-end flag, may interrupt, restarts.
// - Loaded result holds until next period end; a clearing read leaves zero.
// - A new half-cycle count takes effect only from the next period.
// - Ampere-hour mode accumulates rms current into apparent energy and pulses.
// - Ampere-hour mode keeps apparent no-load suppression on the current quantity.
// - Both reactive integration stages are signed.
module reactive_apparent_energy_accumulator #(
    parameter int CHANNELS = 2
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [9:0] regAddr,
    input wire logic [23:0] regWdata,
    input wire logic regWrite,
    input wire logic regRead,
    output logic [23:0] regRdata,
    input wire logic zeroCross,
    input wire logic [23:0] activePowerA,
    input wire logic [23:0] activePowerB,
    input wire logic [23:0] reactivePowerA,
    input wire logic [23:0] reactivePowerB,
    input wire logic [23:0] apparentPowerA,
    input wire logic [23:0] apparentPowerB,
    input wire logic [23:0] rmsCurrentA,
    input wire logic [23:0] rmsCurrentB,
    input wire logic reactiveNoLoadA,
    input wire logic reactiveNoLoadB,
    input wire logic apparentNoLoadA,
    input wire logic apparentNoLoadB,
    output logic irqOut_n,
    output logic apparentStepA,
    output logic apparentStepB,
    output logic reactiveStepA,
    output logic reactiveStepB,
    output logic reactiveDownA,
    output logic reactiveDownB
);
    // ==========================================================
    // Elaboration check
    if (CHANNELS != 2) begin : g_bad_channels
        $error("Only two current channels are supported");
    end

    // ==========================================================
    // State
    typedef struct packed {
        logic [10:0] sampleDiv;
        logic [1:0][1:0][47:0] acc;
        logic [1:0][1:0][5:0] gap;
        logic [1:0][1:0][23:0] run;
        logic [1:0][1:0][23:0] energy;
        logic [1:0][1:0] step;
        logic [1:0][1:0] down;
        logic [1:0][23:0] apPower;
        logic [1:0] reSign;
        logic [7:0] lineMode;
        logic [15:0] halfCount;
        logic [15:0] periodCount;
        logic [15:0] crossCount;
        logic [4:0] accumulation_mode_control;
        logic [1:0][23:0] evEnable;
        logic [1:0][23:0] evStatus;
        logic [23:0] rdata;
        logic irq_n;
    } state_t;

    state_t state_reg;
    state_t state_next;
    logic tick;
    logic lcActive;
    logic cycleEnd;
    logic [1:0][1:0][47:0] add;
    logic [1:0][1:0] clrRd;
    logic [1:0][23:0] activeIn;
    logic [1:0][23:0] reactiveIn;
    logic [1:0][23:0] apparentIn;
    logic [1:0][23:0] rmsIn;
    logic [1:0] reNoLoad;
    logic [1:0] apNoLoad;

    assign activeIn = {activePowerB, activePowerA};
    assign reactiveIn = {reactivePowerB, reactivePowerA};
    assign apparentIn = {apparentPowerB, apparentPowerA};
    assign rmsIn = {rmsCurrentB, rmsCurrentA};
    assign reNoLoad = {reactiveNoLoadB, reactiveNoLoadA};
    assign apNoLoad = {apparentNoLoadB, apparentNoLoadA};

    // ==========================================================
    // Helpers
    // First stage: add the sample, then take one step if the threshold is crossed
    function automatic logic [49:0] integrate(input logic [47:0] acc,
            input logic [47:0] inc, input logic open);
        logic [47:0] sum;
        sum = acc + inc;
        if (open && $signed(sum) >= $signed(energy_accum_pkg::STEP_THRESHOLD)) begin
            integrate = {2'b10, sum - energy_accum_pkg::STEP_THRESHOLD};
        end else if (open && $signed(sum) <= -$signed(energy_accum_pkg::STEP_THRESHOLD)) begin
            integrate = {2'b01, sum + energy_accum_pkg::STEP_THRESHOLD};
        end else begin
            integrate = {2'b00, sum};
        end
    endfunction : integrate

    // Second stage: count one step, report overflow and half-full crossings
    function automatic logic [25:0] bump(input logic [23:0] v, input logic dn);
        logic [23:0] nv;
        nv = dn ? v - 24'h000001 : v + 24'h000001;
        bump = {(dn ? v == 24'h800000 : v == 24'h7FFFFF),
                (nv[23] ^ nv[22]) & ~(v[23] ^ v[22]), nv};
    endfunction : bump

    // ==========================================================
    // Next-state logic
    always_comb begin
        logic [47:0] ext;
        logic [23:0] sel;
        logic [49:0] res;
        logic [25:0] cnt;
        logic [23:0] base;
        logic [1:0] mode;
        logic lcOn;
        logic moved;
        logic [1:0][23:0] evSet;
        logic [1:0][23:0] evClr;
        ext = '0;
        sel = '0;
        res = '0;
        cnt = '0;
        base = '0;
        mode = '0;
        lcOn = 1'b0;
        moved = 1'b0;
        evSet = '0;
        evClr = '0;
        add = '0;
        clrRd = '0;
        state_next = state_reg;
        state_next.rdata = '0;

        // Sample rate divider, one enable pulse per sample period
        tick = state_reg.sampleDiv == energy_accum_pkg::SAMPLE_LAST;
        state_next.sampleDiv = tick ? 11'h000 : state_reg.sampleDiv + 11'h001;

        // Line-cycle period: count zero crossings against the latched count
        lcActive = |state_reg.lineMode[3:0];
        cycleEnd = 1'b0;
        if (!lcActive) begin
            state_next.crossCount = '0;
            state_next.periodCount = state_reg.halfCount;
        end else if (zeroCross) begin
            if ({1'b0, state_reg.crossCount} + 17'h00001 >= {1'b0, state_reg.periodCount}) begin
                cycleEnd = 1'b1;
                state_next.crossCount = '0;
                state_next.periodCount = state_reg.halfCount;
            end else begin
                state_next.crossCount = state_reg.crossCount + 16'h0001;
            end
        end

        // Sample shaping per channel
        for (int c = 0; c < CHANNELS; c++) begin
            mode = state_reg.accumulation_mode_control[energy_accum_pkg::MODE_FIELD_A + 2 * c +: 2];
            ext = {{24{reactiveIn[c][23]}}, reactiveIn[c]};
            case (mode)
                energy_accum_pkg::RE_ACTIVE_SIGN: begin
                    add[1][c] = activeIn[c][23] ? -ext : ext;
                end
                energy_accum_pkg::RE_ABSOLUTE: begin
                    add[1][c] = reNoLoad[c] ? '0 : (ext[47] ? -ext : ext);
                end
                default: begin
                    add[1][c] = ext;
                end
            endcase
            // Ampere-hour swaps the quantity; no-load still suppresses it
            sel = state_reg.accumulation_mode_control[energy_accum_pkg::AMP_HOUR_BIT] ? rmsIn[c] : apparentIn[c];
            add[0][c] = apNoLoad[c] ? '0 : {24'h000000, sel};
            if (!tick) begin
                add[0][c] = '0;
                add[1][c] = '0;
            end
            if (tick) begin
                state_next.apPower[c] = apparentIn[c];
                state_next.reSign[c] = reactiveIn[c][23];
            end
        end

        // Two-stage integration, apparent (p=0) and reactive (p=1)
        for (int p = 0; p < 2; p++) begin
            for (int c = 0; c < CHANNELS; c++) begin
                res = integrate(state_reg.acc[p][c], add[p][c], state_reg.gap[p][c] == 6'h00);
                moved = res[49] | res[48];
                state_next.acc[p][c] = res[47:0];
                state_next.step[p][c] = moved;
                state_next.down[p][c] = res[48];
                // Steps are spaced so full scale never beats the step period
                if (moved) begin
                    state_next.gap[p][c] = energy_accum_pkg::STEP_GAP_LAST;
                end else if (state_reg.gap[p][c] != 6'h00) begin
                    state_next.gap[p][c] = state_reg.gap[p][c] - 6'h01;
                end
                clrRd[p][c] = regRead && regAddr == energy_accum_pkg::ADDR_ENERGY[p][c]
                    && state_reg.lineMode[energy_accum_pkg::LC_CLEAR_ON_READ];
                if (regRead && regAddr == energy_accum_pkg::ADDR_ENERGY[p][c]) begin
                    state_next.rdata = state_reg.energy[p][c];
                end
                lcOn = p == 0 ? state_reg.lineMode[energy_accum_pkg::LC_APPARENT_A + c]
                    : state_reg.lineMode[energy_accum_pkg::LC_REACTIVE_A + c];
                // A step landing with a clearing read counts from zero
                base = clrRd[p][c] ? 24'h000000 : state_reg.energy[p][c];
                cnt = bump(lcOn ? state_reg.run[p][c] : base, res[48]);
                if (clrRd[p][c]) begin
                    state_next.energy[p][c] = '0;
                end
                if (lcOn) begin
                    if (moved) begin
                        state_next.run[p][c] = cnt[23:0];
                    end
                    if (cycleEnd) begin
                        state_next.energy[p][c] = moved ? cnt[23:0] : state_reg.run[p][c];
                        state_next.run[p][c] = '0;
                    end
                end else begin
                    state_next.run[p][c] = '0;
                    if (moved) begin
                        state_next.energy[p][c] = cnt[23:0];
                    end
                end
                evSet[c][2 * p + energy_accum_pkg::EV_HALF] = moved & cnt[24];
                evSet[c][2 * p + energy_accum_pkg::EV_OVERFLOW] = moved & cnt[25];
            end
        end
        evSet[0][energy_accum_pkg::EV_CYCLE_END] = cycleEnd;

        // Register writes; status bits clear by writing one
        if (regWrite) begin
            case (regAddr)
                energy_accum_pkg::ADDR_LINE_MODE: state_next.lineMode = regWdata[7:0];
                energy_accum_pkg::ADDR_HALF_COUNT: state_next.halfCount = regWdata[15:0];
                energy_accum_pkg::ADDR_ACC_MODE: state_next.accumulation_mode_control = regWdata[4:0];
                default: ;
            endcase
        end
        for (int c = 0; c < CHANNELS; c++) begin
            if (regWrite && regAddr == energy_accum_pkg::ADDR_EV_ENABLE[c]) begin
                state_next.evEnable[c] = regWdata;
            end
            if (regWrite && regAddr == energy_accum_pkg::ADDR_EV_STATUS[c]) begin
                evClr[c] = regWdata;
            end
            // A new event beats a clear in the same cycle
            state_next.evStatus[c] = (state_reg.evStatus[c] & ~evClr[c]) | evSet[c];
            if (regRead && regAddr == energy_accum_pkg::ADDR_EV_ENABLE[c]) begin
                state_next.rdata = state_reg.evEnable[c];
            end
            if (regRead && regAddr == energy_accum_pkg::ADDR_EV_STATUS[c]) begin
                state_next.rdata = state_reg.evStatus[c];
            end
            if (regRead && regAddr == energy_accum_pkg::ADDR_AP_POWER[c]) begin
                state_next.rdata = state_reg.apPower[c];
            end
        end

        // Register reads of configuration; unmapped reads return zero
        if (regRead) begin
            case (regAddr)
                energy_accum_pkg::ADDR_LINE_MODE: state_next.rdata = {16'h0000, state_reg.lineMode};
                energy_accum_pkg::ADDR_HALF_COUNT: state_next.rdata = {8'h00, state_reg.halfCount};
                energy_accum_pkg::ADDR_ACC_MODE: begin
                    state_next.rdata = {14'h0000, state_reg.reSign, 3'h0, state_reg.accumulation_mode_control};
                end
                default: ;
            endcase
        end

        // Interrupt pin follows enabled status, registered so it never glitches
        state_next.irq_n = ~|((state_next.evStatus[0] & state_next.evEnable[0])
            | (state_next.evStatus[1] & state_next.evEnable[1]));
    end

    // ==========================================================
    // State register
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= '0;
            state_reg.lineMode <= energy_accum_pkg::LINE_MODE_RESET;
            state_reg.halfCount <= energy_accum_pkg::HALF_COUNT_RESET;
            state_reg.periodCount <= energy_accum_pkg::HALF_COUNT_RESET;
            state_reg.irq_n <= 1'b1;
        end else begin
            state_reg <= state_next;
        end
    end

    // ==========================================================
    // Outputs, all straight from the state register
    assign regRdata = state_reg.rdata;
    assign irqOut_n = state_reg.irq_n;
    assign apparentStepA = state_reg.step[0][0];
    assign apparentStepB = state_reg.step[0][1];
    assign reactiveStepA = state_reg.step[1][0];
    assign reactiveStepB = state_reg.step[1][1];
    assign reactiveDownA = state_reg.down[1][0];
    assign reactiveDownB = state_reg.down[1][1];

    // ==========================================================
    // Assertions
    property p_step_spacing;
        @(posedge clk) disable iff (!rst_n)
        apparentStepA |=> !apparentStepA [*8];
    endproperty
    a_step_spacing: assert property (p_step_spacing) else $error("Steps too close");

    property p_wrap_up;
        @(posedge clk) disable iff (!rst_n)
        (state_reg.energy[0][0] == 24'h7FFFFF && state_next.step[0][0]
            && !state_next.down[0][0] && !state_reg.lineMode[2] && !clrRd[0][0])
        |=> state_reg.energy[0][0] == 24'h800000;
    endproperty
    a_wrap_up: assert property (p_wrap_up) else $error("No wrap to 0x800000");

    property p_clear_read;
        @(posedge clk) disable iff (!rst_n)
        (clrRd[0][1] && !state_next.step[0][1] && !cycleEnd)
        |=> state_reg.energy[0][1] == 24'h000000;
    endproperty
    a_clear_read: assert property (p_clear_read) else $error("Read did not clear");

    property p_cycle_flag;
        @(posedge clk) disable iff (!rst_n)
        cycleEnd |=> state_reg.evStatus[0][energy_accum_pkg::EV_CYCLE_END];
    endproperty
    a_cycle_flag: assert property (p_cycle_flag) else $error("Cycle end flag missing");

    property p_count_held;
        @(posedge clk) disable iff (!rst_n)
        (lcActive && $past(lcActive) && !cycleEnd) |=> $stable(state_reg.periodCount);
    endproperty
    a_count_held: assert property (p_count_held) else $error("Count changed mid period");

    property p_power_rate;
        @(posedge clk) disable iff (!rst_n)
        !tick |=> $stable(state_reg.apPower);
    endproperty
    a_power_rate: assert property (p_power_rate) else $error("Power moved off sample");

    property p_active_sign;
        @(posedge clk) disable iff (!rst_n)
        (tick && state_reg.accumulation_mode_control[1:0] == energy_accum_pkg::RE_ACTIVE_SIGN
            && activeIn[0][23] && !reactiveIn[0][23] && reactiveIn[0] != 24'h000000)
        |-> add[1][0][47];
    endproperty
    a_active_sign: assert property (p_active_sign) else $error("Sign not flipped");

    property p_absolute_noload;
        @(posedge clk) disable iff (!rst_n)
        (state_reg.accumulation_mode_control[3:2] == energy_accum_pkg::RE_ABSOLUTE && reNoLoad[1])
        |-> add[1][1] == 48'h000000000000;
    endproperty
    a_absolute_noload: assert property (p_absolute_noload) else $error("No-load passed");

    property p_irq_pin;
        @(posedge clk) disable iff (!rst_n)
        |(state_reg.evStatus[1] & state_reg.evEnable[1]) |-> !irqOut_n;
    endproperty
    a_irq_pin: assert property (p_irq_pin) else $error("Enabled event not on pin");
endmodule : reactive_apparent_energy_accumulator

// file: rtl/energy_accum_pkg.sv
package energy_accum_pkg;
    // ==========================================================
    // Register offsets
    localparam logic [9:0] ADDR_LINE_MODE = 10'h004;
    localparam logic [9:0] ADDR_HALF_COUNT = 10'h101;
    localparam logic [9:0] ADDR_ACC_MODE = 10'h201;
    // Per channel, index 0 is channel A
    localparam logic [1:0][9:0] ADDR_AP_POWER = {10'h211, 10'h210};
    localparam logic [1:0][9:0] ADDR_EV_ENABLE = {10'h22F, 10'h22C};
    localparam logic [1:0][9:0] ADDR_EV_STATUS = {10'h230, 10'h22D};
    // Energy registers indexed [path][channel], path 0 apparent, 1 reactive
    localparam logic [1:0][1:0][9:0] ADDR_ENERGY = {10'h221, 10'h220, 10'h223, 10'h222};

    // ==========================================================
    // Field positions and reset values
    localparam int LC_REACTIVE_A = 0;
    localparam int LC_APPARENT_A = 2;
    localparam int LC_CLEAR_ON_READ = 6;
    localparam logic [7:0] LINE_MODE_RESET = 8'h40;
    localparam logic [15:0] HALF_COUNT_RESET = 16'h0064;
    localparam int MODE_FIELD_A = 0;
    localparam int AMP_HOUR_BIT = 4;
    localparam logic [1:0] RE_SIGNED = 2'h0;
    localparam logic [1:0] RE_ACTIVE_SIGN = 2'h1;
    localparam logic [1:0] RE_ABSOLUTE = 2'h2;
    // Event bits: half-full and overflow per path, then cycle end
    localparam int EV_HALF = 0;
    localparam int EV_OVERFLOW = 1;
    localparam int EV_CYCLE_END = 4;

    // ==========================================================
    // Timing
    localparam int CLK_PERIOD_NS = 100;
    localparam int SAMPLE_PERIOD_NS = 143000;
    localparam int SAMPLE_CYCLES = SAMPLE_PERIOD_NS / CLK_PERIOD_NS;
    localparam logic [10:0] SAMPLE_LAST = 11'(SAMPLE_CYCLES - 1);
    localparam int STEP_PERIOD_NS = 4830;
    localparam int STEP_CYCLES = (STEP_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [5:0] STEP_GAP_LAST = 6'(STEP_CYCLES - 1);
    // Full-scale sample and the threshold it crosses once per step period
    localparam logic [47:0] FULL_SCALE = 48'h00000004A3E41;
    localparam logic [47:0] STEP_THRESHOLD =
        48'(FULL_SCALE * STEP_PERIOD_NS / SAMPLE_PERIOD_NS);
endpackage : energy_accum_pkg

// file: verification/testbench.sv
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    // ==========================================================
    // Stimulus, observed outputs and bookkeeping
    localparam logic [23:0] TH = 24'(energy_accum_pkg::STEP_THRESHOLD);
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [9:0] regAddr = 10'h000;
    logic [23:0] regWdata = 24'h000000;
    logic regWrite = 1'b0, regRead = 1'b0, zeroCross = 1'b0;
    logic [23:0] activePowerA = 24'h000000, activePowerB = 24'h000000;
    logic [23:0] reactivePowerA = 24'h000000, reactivePowerB = 24'h000000;
    logic [23:0] apparentPowerA = 24'h000000, apparentPowerB = 24'h000000;
    logic [23:0] rmsCurrentA = 24'h000000, rmsCurrentB = 24'h000000;
    logic reactiveNoLoadA = 1'b0, reactiveNoLoadB = 1'b0;
    logic apparentNoLoadA = 1'b0, apparentNoLoadB = 1'b0;
    logic [23:0] regRdata;
    logic irqOut_n, apparentStepA, apparentStepB, reactiveStepA, reactiveStepB;
    logic reactiveDownA, reactiveDownB, rdTaken;
    logic [23:0] reNet = 24'h000000, apSteps = 24'h000000;
    logic [10:0] phase;
    logic [31:0] seed = 32'h1B37795B;
    logic [23:0] expQ[$];
    int failures = 0;
    int numChecks = 0;
    // Reset table and reactive mode cases: mode, active sign, no-load, expected energy
    logic [9:0] rstAddr[8] = '{energy_accum_pkg::ADDR_LINE_MODE, energy_accum_pkg::ADDR_HALF_COUNT,
        energy_accum_pkg::ADDR_ACC_MODE, energy_accum_pkg::ADDR_EV_ENABLE[0],
        energy_accum_pkg::ADDR_EV_ENABLE[1], energy_accum_pkg::ADDR_EV_STATUS[0],
        energy_accum_pkg::ADDR_ENERGY[0][0], 10'h3FF};
    logic [23:0] rstVal[8] = '{24'h000040, 24'h000064, 24'h0, 24'h0, 24'h0, 24'h0, 24'h0, 24'h0};
    logic [1:0] modes[6] = '{energy_accum_pkg::RE_SIGNED, energy_accum_pkg::RE_ACTIVE_SIGN,
        energy_accum_pkg::RE_ACTIVE_SIGN, energy_accum_pkg::RE_ABSOLUTE,
        energy_accum_pkg::RE_ABSOLUTE, 2'h3};
    logic negAct[6] = '{1'b1, 1'b1, 1'b0, 1'b1, 1'b1, 1'b1};
    logic noLd[6] = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0};
    logic [23:0] rExp[6] = '{24'hFFFFFF, 24'h000001, 24'hFFFFFF, 24'h000001, 24'h0, 24'hFFFFFF};

    reactive_apparent_energy_accumulator i_reactive_apparent_energy_accumulator (
        .clk(clk), .rst_n(rst_n), .regAddr(regAddr), .regWdata(regWdata),
        .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata), .zeroCross(zeroCross),
        .activePowerA(activePowerA), .activePowerB(activePowerB),
        .reactivePowerA(reactivePowerA), .reactivePowerB(reactivePowerB),
        .apparentPowerA(apparentPowerA), .apparentPowerB(apparentPowerB),
        .rmsCurrentA(rmsCurrentA), .rmsCurrentB(rmsCurrentB),
        .reactiveNoLoadA(reactiveNoLoadA), .reactiveNoLoadB(reactiveNoLoadB),
        .apparentNoLoadA(apparentNoLoadA), .apparentNoLoadB(apparentNoLoadB),
        .irqOut_n(irqOut_n), .apparentStepA(apparentStepA), .apparentStepB(apparentStepB),
        .reactiveStepA(reactiveStepA), .reactiveStepB(reactiveStepB),
        .reactiveDownA(reactiveDownA), .reactiveDownB(reactiveDownB));

    // ==========================================================
    // Clock, sample-phase tracker and read monitor
    initial begin
        forever #50 clk = ~clk;
    end
    // Phase mirrors the sample divider so reads avoid steps
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            phase <= 11'h000;
            rdTaken <= 1'b0;
        end else begin
            phase <= (phase == 11'h595) ? 11'h000 : phase + 11'h001;
            rdTaken <= regRead;
        end
    end
    // Read data stands only in the cycle after the strobe, so look mid-cycle
    always @(negedge clk) begin
        if (rdTaken === 1'b1) check24(regRdata, expQ.pop_front());
        reNet += {{23{reactiveDownA}}, reactiveStepA} + {{23{reactiveDownB}}, reactiveStepB};
        apSteps += 24'(apparentStepA) + 24'(apparentStepB);
    end

    // ==========================================================
    // Tasks
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {1'b0, s[31:1]} ^ (s[0] ? 32'hA3000000 : 32'h00000000);
    endfunction : lfsr
    task automatic check24(input logic [23:0] got, input logic [23:0] exp);
        numChecks++;
        if (got !== exp) begin
            failures++;
            $display("Error at %0t: read %h, expected %h", $time, got, exp);
        end
    endtask : check24
    task automatic irqIs(input logic exp);
        @(negedge clk);
        numChecks++;
        if (irqOut_n !== exp) begin
            failures++;
            $display("Error at %0t: interrupt pin %b, expected %b", $time, irqOut_n, exp);
        end
    endtask : irqIs
    task automatic wr(input logic [9:0] a, input logic [23:0] d);
        @(posedge clk);
        regWrite <= 1'b1;
        regAddr <= a;
        regWdata <= d;
        @(posedge clk);
        regWrite <= 1'b0;
    endtask : wr
    task automatic rd(input logic [9:0] a, input logic [23:0] e);
        @(posedge clk);
        regRead <= 1'b1;
        regAddr <= a;
        expQ.push_back(e);
        @(posedge clk);
        regRead <= 1'b0;
    endtask : rd
    task automatic waitPhase(input logic [10:0] p);
        do @(posedge clk); while (phase !== p);
    endtask : waitPhase
    task automatic nextFrame(input logic [10:0] p);
        waitPhase(11'h595);
        waitPhase(p);
    endtask : nextFrame
    // Zero crossings sit mid-frame, away from the sample tick
    task automatic zc(input int n);
        repeat (n) begin
            waitPhase(11'h3E8);
            zeroCross <= 1'b1;
            @(posedge clk);
            zeroCross <= 1'b0;
        end
    endtask : zc
    task automatic results();
        $display("Checks: %0d, failures: %0d", numChecks, failures);
        if (failures == 0 && numChecks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : results

    // ==========================================================
    // Watchdog: the sequence needs about 30000 cycles
    initial begin
        repeat (60000) @(posedge clk);
        failures++;
        results();
    end

    // ==========================================================
    // Main sequence
    initial begin
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        for (int i = 0; i < 8; i++) rd(rstAddr[i], rstVal[i]);
        seed = lfsr(seed);
        wr(energy_accum_pkg::ADDR_HALF_COUNT, {8'h00, seed[15:0]});
        rd(energy_accum_pkg::ADDR_HALF_COUNT, {8'h00, seed[15:0]});
        wr(energy_accum_pkg::ADDR_HALF_COUNT, 24'h00FFFF);
        rd(energy_accum_pkg::ADDR_HALF_COUNT, 24'h00FFFF);
        // Threshold multiples leave no residue
        apparentPowerA <= TH << 1;
        apparentPowerB <= TH;
        repeat (3) nextFrame(11'h2BC);
        check24(apSteps, 24'h000009);
        rd(energy_accum_pkg::ADDR_ENERGY[0][0], 24'h000006);
        rd(energy_accum_pkg::ADDR_ENERGY[0][1], 24'h000003);
        rd(energy_accum_pkg::ADDR_ENERGY[0][0], 24'h000000);
        wr(energy_accum_pkg::ADDR_AP_POWER[0], 24'h000000);
        rd(energy_accum_pkg::ADDR_AP_POWER[0], TH << 1);
        rd(energy_accum_pkg::ADDR_AP_POWER[1], TH);
        wr(energy_accum_pkg::ADDR_LINE_MODE, 24'h000000);
        nextFrame(11'h2BC);
        rd(energy_accum_pkg::ADDR_ENERGY[0][0], 24'h000002);
        rd(energy_accum_pkg::ADDR_ENERGY[0][0], 24'h000002);
        wr(energy_accum_pkg::ADDR_LINE_MODE, 24'h000040);
        rd(energy_accum_pkg::ADDR_ENERGY[0][0], 24'h000002);
        wr(energy_accum_pkg::ADDR_ACC_MODE, 24'h000010);
        rmsCurrentA <= TH + (TH << 1);
        rmsCurrentB <= TH;
        nextFrame(11'h2BC);
        rd(energy_accum_pkg::ADDR_ENERGY[0][0], 24'h000003);
        rd(energy_accum_pkg::ADDR_ENERGY[0][1], 24'h000002);
        apparentNoLoadA <= 1'b1;
        nextFrame(11'h2BC);
        rd(energy_accum_pkg::ADDR_ENERGY[0][0], 24'h000000);
        apparentNoLoadA <= 1'b0;
        wr(energy_accum_pkg::ADDR_ACC_MODE, 24'h000000);
        // Reactive modes on both channels, active power magnitude random
        reactivePowerA <= -TH;
        reactivePowerB <= -TH;
        for (int i = 0; i < 6; i++) begin
            seed = lfsr(seed);
            wr(energy_accum_pkg::ADDR_ACC_MODE, {20'h00000, modes[i], modes[i]});
            activePowerA <= negAct[i] ? {1'b1, seed[22:0]} : {1'b0, seed[22:0] | 23'h000001};
            activePowerB <= negAct[i] ? {1'b1, seed[30:8]} : {1'b0, seed[30:8] | 23'h000001};
            reactiveNoLoadA <= noLd[i];
            reactiveNoLoadB <= noLd[i];
            nextFrame(11'h2BC);
            rd(energy_accum_pkg::ADDR_ENERGY[1][0], rExp[i]);
            rd(energy_accum_pkg::ADDR_ENERGY[1][1], rExp[i]);
        end
        check24(reNet, 24'hFFFFFE);
        reactivePowerA <= 24'h000000;
        reactivePowerB <= 24'h000000;
        wr(energy_accum_pkg::ADDR_ACC_MODE, 24'h000000);
        // Line-cycle mode; the first period is unaligned and only its flag is used
        wr(energy_accum_pkg::ADDR_HALF_COUNT, 24'h000002);
        wr(energy_accum_pkg::ADDR_LINE_MODE, 24'h000044);
        zc(2);
        waitPhase(11'h4B0);
        irqIs(1'b1);
        rd(energy_accum_pkg::ADDR_EV_STATUS[0], 24'h000010);
        wr(energy_accum_pkg::ADDR_EV_STATUS[0], 24'h000010);
        wr(energy_accum_pkg::ADDR_EV_ENABLE[0], 24'h000010);
        zc(2);
        waitPhase(11'h4B0);
        irqIs(1'b0);
        rd(energy_accum_pkg::ADDR_ENERGY[0][0], 24'h000004);
        rd(energy_accum_pkg::ADDR_ENERGY[0][0], 24'h000000);
        wr(energy_accum_pkg::ADDR_EV_STATUS[0], 24'h000010);
        repeat (2) @(posedge clk);
        irqIs(1'b1);
        zc(1);
        nextFrame(11'h2BC);
        rd(energy_accum_pkg::ADDR_ENERGY[0][0], 24'h000000);
        wr(energy_accum_pkg::ADDR_HALF_COUNT, 24'h000003);
        zc(1);
        waitPhase(11'h4B0);
        rd(energy_accum_pkg::ADDR_ENERGY[0][0], 24'h000004);
        zc(3);
        waitPhase(11'h4B0);
        rd(energy_accum_pkg::ADDR_ENERGY[0][0], 24'h000006);
        repeat (4) @(posedge clk);
        results();
    end
endmodule : testbench
